// >>> ssh_host_port.sv
// Purpose: master end of the serial host port, two-wire or four-wire per command
// Assumes: user holds wdata_i valid and advances it after each wdata_take_o
// Notes: link clocks come from a quarter-bit divider; four-wire clock idles high
`timescale 1ns/100ps
`default_nettype none
module ssh_host_port
	import ssh_pkg::*;
#(
	parameter int SPI_QTR = SPI_QTR_CYC,
	parameter int I2C_QTR = I2C_QTR_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	ssh_link_if.host        link,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_spi_i,
	input  wire logic       cmd_read_i,
	input  wire logic [7:0] cmd_index_i,
	input  wire logic [7:0] cmd_count_i,
	input  wire logic       cmd_dev_lsb_i,
	input  wire logic [7:0] wdata_i,
	output logic            cmd_ready_o,
	output logic            wdata_take_o,
	output logic      [7:0] rdata_o,
	output logic            rdata_valid_o,
	output logic            done_o,
	output logic            nack_o
);
	logic [1:0]         in_s1_reg, in_s2_reg;
	logic               tick, ack_seen;
	ssh_host_state_type st_reg, st_next;
	ssh_stage_type      stg_reg, stg_next;
	logic [TICK_W-1:0]  tk_reg, tk_next;
	logic [1:0]         q_reg, q_next;
	logic [3:0]         bit_reg, bit_next;
	logic [7:0]         sh_reg, sh_next, rx_reg, rx_next, rem_reg, rem_next;
	logic               spi_reg, spi_next, rd_reg, rd_next, lsb_reg, lsb_next;
	logic               sec_reg, sec_next, rxm_reg, rxm_next;
	logic               scl_reg, scl_next, sdaoe_reg, sdaoe_next;
	logic               sclk_reg, sclk_next, cs_reg, cs_next, mosi_reg, mosi_next;
	logic               rdy_reg, rdy_next, take_reg, take_next;
	logic [7:0]         rdat_reg, rdat_next;
	logic               rv_reg, rv_next, done_reg, done_next, nack_reg, nack_next;
	logic               smp;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_s1_reg <= 2'h3;
			in_s2_reg <= 2'h3;
		end else begin
			in_s1_reg <= {link.miso, link.sda};
			in_s2_reg <= in_s1_reg;
		end
	end

	assign tick     = (tk_reg == '0);
	assign smp      = spi_reg ? in_s2_reg[1] : in_s2_reg[0];
	assign ack_seen = ~in_s2_reg[0];

	always_comb begin
		st_next = st_reg;
		stg_next = stg_reg;
		tk_next = tk_reg;
		q_next = q_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		rx_next = rx_reg;
		rem_next = rem_reg;
		spi_next = spi_reg;
		rd_next = rd_reg;
		lsb_next = lsb_reg;
		sec_next = sec_reg;
		rxm_next = rxm_reg;
		scl_next = scl_reg;
		sdaoe_next = sdaoe_reg;
		sclk_next = sclk_reg;
		cs_next = cs_reg;
		mosi_next = mosi_reg;
		rdy_next = rdy_reg;
		rdat_next = rdat_reg;
		take_next = 1'h0;
		rv_next = 1'h0;
		done_next = 1'h0;
		nack_next = 1'h0;

		if (!tick) begin
			tk_next = tk_reg - 1'h1;
		end else if (st_reg != H_IDLE) begin
			tk_next = spi_reg ? TICK_W'(SPI_QTR - 1) : TICK_W'(I2C_QTR - 1);
			q_next  = q_reg + 2'h1;
		end

		case (st_reg)
			H_IDLE: begin
				if (cmd_valid_i && rdy_reg) begin
					rdy_next = 1'h0;
					spi_next = cmd_spi_i;
					rd_next  = cmd_read_i;
					lsb_next = cmd_dev_lsb_i;
					rem_next = (cmd_count_i == 8'h00) ? 8'h01 : cmd_count_i;
					q_next   = 2'h0;
					bit_next = 4'h0;
					sec_next = 1'h0;
					rxm_next = 1'h0;
					stg_next = STG_ADDR;
					tk_next  = cmd_spi_i ? TICK_W'(SPI_QTR - 1) : TICK_W'(I2C_QTR - 1);
					if (cmd_spi_i) begin
						cs_next = 1'h0;
						st_next = H_SPI;
						sh_next = {cmd_read_i, cmd_index_i[6:0]};
					end else begin
						st_next = H_START;
						sh_next = {I2C_ADDR_HI, cmd_dev_lsb_i, DIR_WRITE};
					end
				end
			end
			H_START: if (tick) begin
				case (q_reg)
					2'h0: sdaoe_next = 1'h0;
					2'h1: scl_next = 1'h1;
					2'h2: sdaoe_next = 1'h1;
					default: begin
						scl_next = 1'h0;
						st_next  = H_BYTE;
					end
				endcase
			end
			H_STOP: if (tick) begin
				case (q_reg)
					2'h0: sdaoe_next = 1'h1;
					2'h1: scl_next = 1'h1;
					2'h2: sdaoe_next = 1'h0;
					default: begin
						st_next   = H_IDLE;
						rdy_next  = 1'h1;
						done_next = 1'h1;
					end
				endcase
			end
			H_BYTE: if (tick) begin
				case (q_reg)
					2'h0: begin
						if (bit_reg != ACK_BIT) begin
							sdaoe_next = ~rxm_reg & ~sh_reg[7];
						end else begin
							sdaoe_next = rxm_reg & (rem_reg != 8'h01);
						end
					end
					2'h1: scl_next = 1'h1;
					2'h2: scl_next = 1'h1;
					default: begin
						scl_next = 1'h0;
						if (bit_reg != ACK_BIT) begin
							bit_next = bit_reg + 4'h1;
							sh_next  = {sh_reg[6:0], 1'h1};
							rx_next  = {rx_reg[6:0], smp};
						end else begin
							bit_next   = 4'h0;
							sdaoe_next = 1'h0;
							if (rxm_reg) begin
								rdat_next = rx_reg;
								rv_next   = 1'h1;
								rem_next  = rem_reg - 8'h01;
								if (rem_reg == 8'h01) begin
									st_next = H_STOP;
								end
							end else if (!ack_seen) begin
								nack_next = 1'h1;
								st_next   = H_STOP;
							end else if (stg_reg == STG_ADDR) begin
								if (sec_reg) begin
									rxm_next = 1'h1;
								end else begin
									stg_next = STG_INDEX;
									sh_next  = cmd_index_i;
								end
							end else if (stg_reg == STG_INDEX && rd_reg) begin
								sec_next = 1'h1;
								stg_next = STG_ADDR;
								sh_next  = {I2C_ADDR_HI, lsb_reg, DIR_READ};
								st_next  = H_START;
							end else if (stg_reg == STG_INDEX || rem_reg != 8'h01) begin
								if (stg_reg == STG_DATA) begin
									rem_next = rem_reg - 8'h01;
								end
								stg_next  = STG_DATA;
								sh_next   = wdata_i;
								take_next = 1'h1;
							end else begin
								st_next = H_STOP;
							end
						end
					end
				endcase
			end
			H_SPI: if (tick) begin
				case (q_reg)
					2'h0: begin
						sclk_next = 1'h0;
						mosi_next = sh_reg[7];
					end
					2'h1: sclk_next = 1'h0;
					2'h2: sclk_next = 1'h1;
					default: begin
						// Sampled mid-way through the high half to cover pin latency
						rx_next  = {rx_reg[6:0], smp};
						sh_next  = {sh_reg[6:0], 1'h1};
						bit_next = bit_reg + 4'h1;
						if (bit_reg == {1'h0, LAST_DATA_BIT[2:0]}) begin
							bit_next = 4'h0;
							if (stg_reg == STG_ADDR) begin
								stg_next  = STG_DATA;
								sh_next   = rd_reg ? IDLE_FILL : wdata_i;
								take_next = ~rd_reg;
							end else begin
								rem_next = rem_reg - 8'h01;
								if (rd_reg) begin
									rdat_next = {rx_reg[6:0], smp};
									rv_next   = 1'h1;
								end
								if (rem_reg == 8'h01) begin
									cs_next   = 1'h1;
									st_next   = H_IDLE;
									rdy_next  = 1'h1;
									done_next = 1'h1;
								end else begin
									sh_next   = rd_reg ? IDLE_FILL : wdata_i;
									take_next = ~rd_reg;
								end
							end
						end
					end
				endcase
			end
			default: st_next = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= H_IDLE;
			stg_reg <= STG_ADDR;
			tk_reg <= '0;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			rx_reg <= 8'h00;
			rem_reg <= 8'h00;
			spi_reg <= 1'h0;
			rd_reg <= 1'h0;
			lsb_reg <= 1'h0;
			sec_reg <= 1'h0;
			rxm_reg <= 1'h0;
			scl_reg <= 1'h1;
			sdaoe_reg <= 1'h0;
			sclk_reg <= 1'h1;
			cs_reg <= 1'h1;
			mosi_reg <= 1'h1;
			rdy_reg <= 1'h1;
			take_reg <= 1'h0;
			rdat_reg <= 8'h00;
			rv_reg <= 1'h0;
			done_reg <= 1'h0;
			nack_reg <= 1'h0;
		end else begin
			st_reg <= st_next;
			stg_reg <= stg_next;
			tk_reg <= tk_next;
			q_reg <= q_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			rx_reg <= rx_next;
			rem_reg <= rem_next;
			spi_reg <= spi_next;
			rd_reg <= rd_next;
			lsb_reg <= lsb_next;
			sec_reg <= sec_next;
			rxm_reg <= rxm_next;
			scl_reg <= scl_next;
			sdaoe_reg <= sdaoe_next;
			sclk_reg <= sclk_next;
			cs_reg <= cs_next;
			mosi_reg <= mosi_next;
			rdy_reg <= rdy_next;
			take_reg <= take_next;
			rdat_reg <= rdat_next;
			rv_reg <= rv_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
		end
	end

	assign link.scl         = scl_reg;
	assign link.host_sda_o  = 1'h0;
	assign link.host_sda_oe = sdaoe_reg;
	assign link.sclk        = sclk_reg;
	assign link.cs_n        = cs_reg;
	assign link.mosi        = mosi_reg;
	assign cmd_ready_o      = rdy_reg;
	assign wdata_take_o     = take_reg;
	assign rdata_o          = rdat_reg;
	assign rdata_valid_o    = rv_reg;
	assign done_o           = done_reg;
	assign nack_o           = nack_reg;
endmodule
`default_nettype wire

// >>> ssh_pkg.sv
// Purpose: shared constants and types for the sensor serial host port
// Assumes: both ends run on a 125 MHz core clock
// Notes: quarter-bit counts are rounded up so link clocks never run too fast
// Notes on behaviour
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Acknowledge: receiver holds data low, ninth clock
// - Not-acknowledge: data high; device stops sending
// - Read: address+write, index, restart, address+read
// - Device address upper bits fixed, LSB pin
// - Burst write stores into successive registers
// - Four-wire master sets two-wire port disable; host has no such output, device masks two-wire while chip select low
// - Four-wire device is slave only
// - Chip select low frames one transaction
// - Output released while chip select high
// - Bytes shift most significant bit first
// - Data sampled on serial clock rise
// - Data changed on serial clock fall
// - Four-wire clock at most 8 MHz
// - Transfer is at least sixteen clocks
// - First byte command, then data bytes
// - Command bit 7: one read, zero write
// - Command low seven bits: register index
// - Single and burst access per select
package ssh_pkg;
	localparam int         CLK_PERIOD_NS     = 8;
	localparam int         SPI_MIN_PERIOD_NS = 125;
	localparam int         I2C_MIN_PERIOD_NS = 2500;
	localparam int         SPI_QTR_CYC       = (SPI_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
		/ (4 * CLK_PERIOD_NS);
	localparam int         I2C_QTR_CYC       = (I2C_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
		/ (4 * CLK_PERIOD_NS);
	localparam int         TICK_W            = 8;
	localparam logic [5:0] I2C_ADDR_HI       = 6'h34;
	localparam logic       DIR_WRITE         = 1'h0;
	localparam logic       DIR_READ          = 1'h1;
	localparam logic [3:0] LAST_DATA_BIT     = 4'h7;
	localparam logic [3:0] ACK_BIT           = 4'h8;
	localparam logic [7:0] IDLE_FILL         = 8'hff;
	localparam int         PIN_W             = 6;
	localparam int         P_SCL             = 0;
	localparam int         P_SDA             = 1;
	localparam int         P_SCLK            = 2;
	localparam int         P_CS              = 3;
	localparam int         P_MOSI            = 4;
	localparam int         P_LSB             = 5;
	localparam logic [5:0] PIN_IDLE          = 6'h1f;

	typedef enum logic [4:0] {
		I_IDLE  = 5'h01,
		I_ADDR  = 5'h02,
		I_INDEX = 5'h04,
		I_WDATA = 5'h08,
		I_RDATA = 5'h10
	} ssh_dev_state_type;

	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_BYTE  = 5'h04,
		H_STOP  = 5'h08,
		H_SPI   = 5'h10
	} ssh_host_state_type;

	typedef enum logic [2:0] {
		STG_ADDR  = 3'h1,
		STG_INDEX = 3'h2,
		STG_DATA  = 3'h4
	} ssh_stage_type;
endpackage

// >>> ssh_link_if.sv
// Purpose: pins between host and device ends of the serial port
// Assumes: pull-ups on the two-wire data line and the four-wire data output
// Notes: open-drain drivers pull low while their enable is high
`timescale 1ns/100ps
`default_nettype none
interface ssh_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;
	logic address_lsb_select;

	assign sda  = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	assign miso = miso_oe ? miso_o : 1'h1;

	modport host (
		output scl, host_sda_o, host_sda_oe, sclk, cs_n, mosi,
		input  sda, miso
	);
	modport dev (
		input  scl, sda, sclk, cs_n, mosi, address_lsb_select,
		output dev_sda_o, dev_sda_oe, miso_o, miso_oe
	);
endinterface
`default_nettype wire

// >>> ssh_dev_port.sv
// Purpose: device end of the serial host port, two-wire and four-wire slave
// Assumes: register file reads reg_rdata_i combinationally from reg_index_o
// Notes: pins pass three flip-flops; edges compare the second and third stage
`timescale 1ns/100ps
`default_nettype none
module ssh_dev_port
	import ssh_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	ssh_link_if.dev         link,
	input  wire logic       two_wire_port_disable_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic      [7:0] reg_index_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o
);
	logic [PIN_W-1:0]  pins;
	logic [PIN_W-1:0]  pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic              scl, scl_rise, scl_fall, sda, i2c_start, i2c_stop, i2c_on;
	logic              sclk_rise, sclk_fall, cs_hi, mosi;
	ssh_dev_state_type i_state_reg, i_state_next;
	logic [3:0]        i_cnt_reg, i_cnt_next;
	logic [7:0]        i_sh_reg, i_sh_next;
	logic              i_rw_reg, i_rw_next;
	logic              sda_oe_reg, sda_oe_next;
	logic [2:0]        s_cnt_reg, s_cnt_next;
	logic [7:0]        s_sh_reg, s_sh_next;
	logic [7:0]        s_tx_reg, s_tx_next;
	logic              s_first_reg, s_first_next;
	logic              s_rw_reg, s_rw_next;
	logic              s_load_reg, s_load_next;
	logic              s_inc_reg, s_inc_next;
	logic              miso_reg, miso_next;
	logic              miso_oe_reg, miso_oe_next;
	logic [7:0]        index_reg, index_next;
	logic [7:0]        wdata_reg, wdata_next;
	logic              wr_reg, wr_next;
	logic [7:0]        s_byte;

	assign pins = {link.address_lsb_select, link.mosi, link.cs_n, link.sclk, link.sda, link.scl};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1_reg <= PIN_IDLE;
			pin_s2_reg <= PIN_IDLE;
			pin_s3_reg <= PIN_IDLE;
		end else begin
			pin_s1_reg <= pins;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign scl       = pin_s2_reg[P_SCL];
	assign sda       = pin_s2_reg[P_SDA];
	assign scl_rise  = scl & ~pin_s3_reg[P_SCL];
	assign scl_fall  = ~scl & pin_s3_reg[P_SCL];
	assign i2c_start = scl & pin_s3_reg[P_SCL] & ~sda & pin_s3_reg[P_SDA];
	assign i2c_stop  = scl & pin_s3_reg[P_SCL] & sda & ~pin_s3_reg[P_SDA];
	assign cs_hi     = pin_s2_reg[P_CS];
	// A selected four-wire transfer owns the shared pins
	assign i2c_on    = ~two_wire_port_disable_i & cs_hi & pin_s3_reg[P_CS];
	assign sclk_rise = pin_s2_reg[P_SCLK] & ~pin_s3_reg[P_SCLK];
	assign sclk_fall = ~pin_s2_reg[P_SCLK] & pin_s3_reg[P_SCLK];
	assign mosi      = pin_s2_reg[P_MOSI];
	assign s_byte    = {s_sh_reg[6:0], mosi};

	always_comb begin
		i_state_next = i_state_reg;
		i_cnt_next   = i_cnt_reg;
		i_sh_next    = i_sh_reg;
		i_rw_next    = i_rw_reg;
		sda_oe_next  = sda_oe_reg;
		s_cnt_next   = s_cnt_reg;
		s_sh_next    = s_sh_reg;
		s_tx_next    = s_tx_reg;
		s_first_next = s_first_reg;
		s_rw_next    = s_rw_reg;
		s_load_next  = 1'h0;
		s_inc_next   = 1'h0;
		miso_next    = miso_reg;
		miso_oe_next = miso_oe_reg;
		index_next   = index_reg;
		wdata_next   = wdata_reg;
		wr_next      = 1'h0;

		// Two-wire slave
		if (!i2c_on || i2c_stop) begin
			i_state_next = I_IDLE;
			sda_oe_next  = 1'h0;
		end else if (i2c_start) begin
			i_state_next = I_ADDR;
			// Master's own fall after start wraps this to zero, not a bit
			i_cnt_next   = 4'hf;
			sda_oe_next  = 1'h0;
		end else if (scl_rise && i_state_reg != I_IDLE) begin
			if (i_cnt_reg != ACK_BIT) begin
				if (i_state_reg != I_RDATA) begin
					i_sh_next = {i_sh_reg[6:0], sda};
				end
			end else if (i_state_reg == I_RDATA && sda) begin
				i_state_next = I_IDLE;
			end
		end else if (scl_fall && i_state_reg != I_IDLE) begin
			if (i_cnt_reg == LAST_DATA_BIT) begin
				i_cnt_next  = ACK_BIT;
				sda_oe_next = 1'h1;
				case (i_state_reg)
					I_ADDR: begin
						i_rw_next = i_sh_reg[0];
						if (i_sh_reg[7:1] != {I2C_ADDR_HI, pin_s2_reg[P_LSB]}) begin
							i_state_next = I_IDLE;
							sda_oe_next  = 1'h0;
						end
					end
					I_INDEX: index_next = i_sh_reg;
					I_WDATA: begin
						wdata_next = i_sh_reg;
						wr_next    = 1'h1;
					end
					I_RDATA: sda_oe_next = 1'h0;
					default: sda_oe_next = 1'h0;
				endcase
			end else if (i_cnt_reg == ACK_BIT) begin
				i_cnt_next  = 4'h0;
				sda_oe_next = 1'h0;
				case (i_state_reg)
					I_ADDR: i_state_next = (i_rw_reg == DIR_READ) ? I_RDATA : I_INDEX;
					I_INDEX: i_state_next = I_WDATA;
					I_WDATA: index_next = index_reg + 8'h01;
					default: i_state_next = i_state_reg;
				endcase
				// Acked read byte or read address: fetch next register
				if ((i_state_reg == I_ADDR && i_rw_reg == DIR_READ) || i_state_reg == I_RDATA) begin
					i_sh_next   = reg_rdata_i;
					sda_oe_next = ~reg_rdata_i[7];
					index_next  = index_reg + 8'h01;
				end
			end else begin
				i_cnt_next = i_cnt_reg + 4'h1;
				if (i_state_reg == I_RDATA) begin
					i_sh_next   = {i_sh_reg[6:0], 1'h1};
					sda_oe_next = ~i_sh_reg[6];
				end
			end
		end

		// Four-wire slave, never drives its clock or select
		if (cs_hi) begin
			s_cnt_next   = 3'h0;
			s_first_next = 1'h1;
			miso_oe_next = 1'h0;
		end else begin
			miso_oe_next = 1'h1;
			if (s_load_reg) begin
				s_tx_next = reg_rdata_i;
			end
			if (s_inc_reg) begin
				index_next = index_reg + 8'h01;
			end
			if (sclk_rise) begin
				s_sh_next  = s_byte;
				s_cnt_next = s_cnt_reg + 3'h1;
				if (s_cnt_reg == LAST_DATA_BIT[2:0]) begin
					if (s_first_reg) begin
						s_first_next = 1'h0;
						s_rw_next    = s_byte[7];
						index_next   = {1'h0, s_byte[6:0]};
						s_load_next  = (s_byte[7] == DIR_READ);
					end else if (s_rw_reg == DIR_READ) begin
						index_next  = index_reg + 8'h01;
						s_load_next = 1'h1;
					end else begin
						wdata_next = s_byte;
						wr_next    = 1'h1;
						s_inc_next = 1'h1;
					end
				end
			end
			if (sclk_fall && !s_first_reg && s_rw_reg == DIR_READ) begin
				miso_next = s_tx_reg[7];
				s_tx_next = {s_tx_reg[6:0], 1'h1};
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			i_state_reg <= I_IDLE;
			i_cnt_reg   <= 4'h0;
			i_sh_reg    <= 8'h00;
			i_rw_reg    <= DIR_WRITE;
			sda_oe_reg  <= 1'h0;
			s_cnt_reg   <= 3'h0;
			s_sh_reg    <= 8'h00;
			s_tx_reg    <= IDLE_FILL;
			s_first_reg <= 1'h1;
			s_rw_reg    <= DIR_WRITE;
			s_load_reg  <= 1'h0;
			s_inc_reg   <= 1'h0;
			miso_reg    <= 1'h1;
			miso_oe_reg <= 1'h0;
			index_reg   <= 8'h00;
			wdata_reg   <= 8'h00;
			wr_reg      <= 1'h0;
		end else begin
			i_state_reg <= i_state_next;
			i_cnt_reg   <= i_cnt_next;
			i_sh_reg    <= i_sh_next;
			i_rw_reg    <= i_rw_next;
			sda_oe_reg  <= sda_oe_next;
			s_cnt_reg   <= s_cnt_next;
			s_sh_reg    <= s_sh_next;
			s_tx_reg    <= s_tx_next;
			s_first_reg <= s_first_next;
			s_rw_reg    <= s_rw_next;
			s_load_reg  <= s_load_next;
			s_inc_reg   <= s_inc_next;
			miso_reg    <= miso_next;
			miso_oe_reg <= miso_oe_next;
			index_reg   <= index_next;
			wdata_reg   <= wdata_next;
			wr_reg      <= wr_next;
		end
	end

	// Open-drain: only ever pulls low
	assign link.dev_sda_o  = 1'h0;
	assign link.dev_sda_oe = sda_oe_reg;
	assign link.miso_o     = miso_reg;
	assign link.miso_oe    = miso_oe_reg;
	assign reg_index_o     = index_reg;
	assign reg_wdata_o     = wdata_reg;
	assign reg_wr_o        = wr_reg;
endmodule
`default_nettype wire

// >>> ssh_link_props.sv
// Purpose: link checks between the host and device ends
// Assumes: bench runs SPI_QTR 4 and I2C_QTR 10
// Notes: sees link pins only
`timescale 1ns/100ps
`default_nettype none
module ssh_link_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic dev_sda_oe_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic miso_data_i,
	input wire logic miso_oe_i
);
	logic [7:0] rise_cnt_reg;
	logic [7:0] rise_cnt_next;
	logic       sclk_d_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always_comb begin
		rise_cnt_next = cs_n_i ? 8'h00 : rise_cnt_reg + {7'h00, sclk_i & ~sclk_d_reg};
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_cnt_reg <= 8'h00;
			sclk_d_reg   <= 1'h1;
		end else begin
			rise_cnt_reg <= rise_cnt_next;
			sclk_d_reg   <= sclk_i;
		end
	end
	// Pin synchronisers delay the release by a few cycles
	a_miso_released: assert property (cs_n_i [*6] |-> !miso_oe_i)
		else $error("data output driven while deselected");
	a_cs_enables: assert property ($fell(cs_n_i) |-> ##[1:6] miso_oe_i)
		else $error("select did not open a transaction");
	a_mosi_on_fall: assert property (!cs_n_i && !$past(cs_n_i) && $changed(mosi_i) |-> !sclk_i)
		else $error("host data changed while clock high");
	a_miso_on_fall: assert property (miso_oe_i && $past(miso_oe_i) && $changed(miso_data_i)
		|-> !sclk_i)
		else $error("device data changed while clock high");
	a_sclk_low_time: assert property ($fell(sclk_i) |-> !sclk_i [*7])
		else $error("four-wire clock low phase too short");
	a_frame_length: assert property ($rose(cs_n_i)
		|-> rise_cnt_reg >= 8'h10 && rise_cnt_reg[2:0] == 3'h0)
		else $error("frame not whole bytes of at least sixteen clocks");
	a_ack_held: assert property ($rose(scl_i) && dev_sda_oe_i |-> !sda_i [*8])
		else $error("device low level not held through clock high");
	a_stop_idle: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> !dev_sda_oe_i [*8])
		else $error("device drives data after stop");
	a_twowire_change: assert property ($changed(dev_sda_oe_i) |-> !scl_i)
		else $error("device data changed while clock high");
	c_start: cover property ($fell(sda_i) && scl_i);
	c_ack: cover property ($rose(scl_i) && dev_sda_oe_i);
	c_burst: cover property ($rose(cs_n_i) && rise_cnt_reg >= 8'h20);
endmodule
`default_nettype wire

// >>> sensor_serial_host_port_tb_top.sv
// Purpose: self-checking bench, host and device ends facing each other
// Assumes: shortened two-wire quarter-bit count; register file modelled here
// Notes: expected data comes from the row table, never from the design
`timescale 1ns/100ps
`default_nettype none
module sensor_serial_host_port_tb_top;
	typedef struct packed {
		logic       spi;
		logic       rd;
		logic [7:0] idx;
		logic [7:0] cnt;
		logic [7:0] base;
		logic       lsb;
	} ssh_row_type;
	localparam ssh_row_type ROWS [7] = '{
		'{1'h1, 1'h0, 8'h10, 8'h01, 8'ha5, 1'h1},
		'{1'h1, 1'h0, 8'h20, 8'h03, 8'h31, 1'h0},
		'{1'h1, 1'h1, 8'h20, 8'h03, 8'h31, 1'h0},
		'{1'h0, 1'h0, 8'h40, 8'h02, 8'h5c, 1'h1},
		'{1'h0, 1'h1, 8'h40, 8'h02, 8'h5c, 1'h1},
		'{1'h0, 1'h1, 8'h10, 8'h01, 8'ha5, 1'h0},
		'{1'h1, 1'h1, 8'h41, 8'h01, 8'h5d, 1'h0}};
	logic       clk_i = 1'h0;
	logic       rst_n_i = 1'h0;
	logic       cmd_valid_i = 1'h0, cmd_spi_i = 1'h0, cmd_read_i = 1'h0, cmd_dev_lsb_i = 1'h0;
	logic [7:0] cmd_index_i = 8'h00, cmd_count_i = 8'h01, wdata_i = 8'h00;
	logic       port_off = 1'h0, lsb_pin = 1'h0;
	logic       cmd_ready_o, wdata_take_o, rdata_valid_o, done_o, nack_o, reg_wr_o;
	logic [7:0] rdata_o, reg_index_o, reg_wdata_o, reg_rdata_i;
	logic [7:0] mem [256];
	int         miscompares = 0;
	int         checks = 0;

	always #4 clk_i = ~clk_i;
	ssh_link_if ssh_link_if_inst ();
	assign ssh_link_if_inst.address_lsb_select = lsb_pin;
	// Register file answers combinationally, as the device expects
	assign reg_rdata_i = mem[reg_index_o];
	always @(posedge clk_i) if (reg_wr_o === 1'h1) mem[reg_index_o] <= reg_wdata_o;

	ssh_host_port #(.SPI_QTR(4), .I2C_QTR(10)) ssh_host_port_inst (
		.clk_i, .rst_n_i, .link(ssh_link_if_inst.host), .cmd_valid_i, .cmd_spi_i,
		.cmd_read_i, .cmd_index_i, .cmd_count_i, .cmd_dev_lsb_i, .wdata_i, .cmd_ready_o,
		.wdata_take_o, .rdata_o, .rdata_valid_o, .done_o, .nack_o);
	ssh_dev_port ssh_dev_port_inst (
		.clk_i, .rst_n_i, .link(ssh_link_if_inst.dev), .two_wire_port_disable_i(port_off),
		.reg_rdata_i, .reg_index_o, .reg_wdata_o, .reg_wr_o);
	ssh_link_props ssh_link_props_inst (
		.clk_i, .rst_n_i, .scl_i(ssh_link_if_inst.scl), .sda_i(ssh_link_if_inst.sda),
		.dev_sda_oe_i(ssh_link_if_inst.dev_sda_oe), .sclk_i(ssh_link_if_inst.sclk),
		.cs_n_i(ssh_link_if_inst.cs_n), .mosi_i(ssh_link_if_inst.mosi),
		.miso_data_i(ssh_link_if_inst.miso_o), .miso_oe_i(ssh_link_if_inst.miso_oe));

	task automatic chk(input logic bad, input string msg);
		checks++;
		if (bad !== 1'h0) begin
			miscompares++;
			$display("mismatch at %0t ns: %s", $time, msg);
		end
	endtask

	task automatic conclude();
		$display("checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic run(input ssh_row_type r, input logic nk);
		int         n;
		int         rc;
		logic       seen;
		logic [7:0] a;
		n = 0;
		rc = 0;
		seen = 1'h0;
		// Four-wire index is only seven bits wide
		a = r.spi ? {1'h0, r.idx[6:0]} : r.idx;
		@(posedge clk_i);
		#1;
		{cmd_spi_i, cmd_read_i, cmd_index_i, cmd_count_i, wdata_i, cmd_dev_lsb_i} = r;
		cmd_valid_i = 1'h1;
		do begin
			@(posedge clk_i);
			#1;
			cmd_valid_i = 1'h0;
			n++;
			if (wdata_take_o === 1'h1) wdata_i = wdata_i + 8'h01;
			if (rdata_valid_o === 1'h1) begin
				chk(rdata_o !== r.base + rc[7:0], "read data");
				rc++;
			end
			if (nack_o === 1'h1) seen = 1'h1;
		end while (done_o !== 1'h1 && n < 30000);
		if (n >= 30000) begin
			chk(1'h1, "no completion");
			conclude();
		end
		// Last four-wire store lands on the same clock edge as done
		repeat (8) @(posedge clk_i);
		chk(seen !== nk, "acknowledge outcome");
		if (r.rd && !nk) chk(rc != int'(r.cnt), "read byte count");
		for (int j = 0; j < int'(r.cnt) && !r.rd && !nk; j++)
			chk(mem[a + j[7:0]] !== r.base + j[7:0], "stored data");
		$display("test done: spi %0d read %0d index %0h", r.spi, r.rd, r.idx);
	endtask

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		repeat (11) @(posedge clk_i);
		chk(cmd_ready_o !== 1'h1 || ssh_link_if_inst.cs_n !== 1'h1, "host reset");
		chk(ssh_link_if_inst.miso_oe !== 1'h0, "device reset");
		@(posedge clk_i);
		#1;
		rst_n_i = 1'h1;
		repeat (3) @(posedge clk_i);
		$display("test done: reset");
		foreach (ROWS[i]) begin
			lsb_pin = ROWS[i].lsb;
			run(ROWS[i], 1'h0);
		end
		lsb_pin = 1'h0;
		run('{1'h0, 1'h0, 8'h50, 8'h01, 8'h77, 1'h1}, 1'h1);
		chk(mem[8'h50] !== 8'h00, "store at foreign address");
		port_off = 1'h1;
		run('{1'h0, 1'h1, 8'h10, 8'h01, 8'ha5, 1'h0}, 1'h1);
		port_off = 1'h0;
		run('{1'h1, 1'h0, 8'hff, 8'h01, 8'hc3, 1'h0}, 1'h0);
		// Reset in mid-transfer must release the link at once
		@(posedge clk_i);
		#1;
		{cmd_spi_i, cmd_read_i, cmd_index_i, cmd_count_i, wdata_i, cmd_dev_lsb_i} = ROWS[2];
		cmd_valid_i = 1'h1;
		@(posedge clk_i);
		#1;
		cmd_valid_i = 1'h0;
		repeat (40) @(posedge clk_i);
		#1;
		rst_n_i = 1'h0;
		repeat (2) @(posedge clk_i);
		chk(ssh_link_if_inst.cs_n !== 1'h1 || ssh_link_if_inst.miso_oe !== 1'h0, "abort");
		#1;
		rst_n_i = 1'h1;
		repeat (3) @(posedge clk_i);
		$display("test done: reset in transfer");
		run(ROWS[6], 1'h0);
		conclude();
	end
endmodule
`default_nettype wire
